// ---- hdl/pxo_pkg.sv ----
package pxo_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_OUT_CFG   = 8'h24;  // Strobe invert, field polarity
	localparam logic [7:0] IDX_STRB_SEL  = 8'h25;  // Strobe clock select field
	localparam logic [7:0] IDX_PHASE     = 8'h30;  // Sampling phase
	localparam logic [7:0] IDX_CTRL      = 8'h31;  // Clock source, converter, line sync
	localparam logic [7:0] IDX_STATUS    = 8'h32;  // Read-only state

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int BIT_STRB_INV   = 0;
	localparam int BIT_FIELD_POL  = 4;
	localparam int BIT_SEL_LO     = 6;
	localparam int BIT_EXT_SEL    = 0;
	localparam int BIT_CSC_EN     = 1;
	localparam int BIT_HS_POL     = 2;
	localparam int BIT_PROT_ALT   = 3;
	localparam int BIT_HS_WID_LO  = 8;
	localparam int BIT_ST_FIELD   = 0;
	localparam int BIT_ST_LSYNC   = 1;
	localparam int BIT_ST_CFGA_LO = 8;
	localparam int BIT_ST_PRTA_LO = 16;

	////////////////////////////////////////////////////////////////////////////
	// Reset values and fixed codes
	localparam logic [7:0] HS_WIDTH_RST   = 8'h08;
	localparam logic [1:0] PHASE_RST      = 2'h0;
	localparam logic [7:0] CFG_BUS_ADDR   = 8'h98;
	localparam logic [7:0] PROT_ADDR_A    = 8'h74;
	localparam logic [7:0] PROT_ADDR_B    = 8'h76;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;
	localparam logic [1:0] ALIGN_ZERO     = 2'h0;
	localparam int         PHASES         = 4;      // aclk cycles per pixel

	// Strobe clock options in field order
	typedef enum logic [1:0] {
		strb_half,
		strb_pixel,
		strb_double,
		strb_quad
	} pxo_strobe_t;

endpackage : pxo_pkg

// ---- hdl/pxo_strobe_gen.sv ----
`timescale 1ns/1ps
module pxo_strobe_gen (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ce,
	input  wire logic       ext_sel,
	input  wire logic       external_pixel_clock_in,
	input  wire logic [1:0] phase,
	input  wire logic [1:0] strb_sel,
	output logic            pix_tick,
	output logic            strobe_raw
);

	typedef struct packed {
		logic       sync1;
		logic       sync2;
		logic       prev;
		logic [1:0] ph;
		logic       half;
		logic       tick;
		logic       strobe;
	} pxo_gen_state_t;

	pxo_gen_state_t r;
	pxo_gen_state_t n;

	assign pix_tick   = r.tick;
	assign strobe_raw = r.strobe;

	////////////////////////////////////////////////////////////////////////////
	// Phase counter and strobe shaping; every option derives from the same phase
	always_comb begin
		logic [1:0] a;
		a = '0;
		n = r;
		n.sync1 = external_pixel_clock_in;
		n.sync2 = r.sync1;
		n.prev  = r.sync2;
		// External edge realigns the pixel phase, else free-running internal clock
		n.ph = (ext_sel && r.sync2 && !r.prev) ? pxo_pkg::ALIGN_ZERO : r.ph + 2'h1;
		a = n.ph - phase;
		n.tick = (a == pxo_pkg::ALIGN_ZERO);
		if (n.tick) begin
			n.half = !r.half;
		end
		unique case (pxo_pkg::pxo_strobe_t'(strb_sel))
			pxo_pkg::strb_half:   n.strobe = n.half;
			pxo_pkg::strb_pixel:  n.strobe = !a[1];
			pxo_pkg::strb_double: n.strobe = !a[0];
			pxo_pkg::strb_quad:   n.strobe = a[0] ^ a[1];
		endcase
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Both compared strobe samples must come from steady phase and no external realign
	a_double_rate_toggle: assert property ($past(ce) && $past(ce, 2) && $past(aresetn) && $past(aresetn, 2)
		&& $past(strb_sel) == pxo_pkg::strb_double && $past(strb_sel, 2) == pxo_pkg::strb_double
		&& !$past(ext_sel) && $past(phase) == $past(phase, 2) |-> strobe_raw != $past(strobe_raw))
		else $error("double rate strobe did not toggle");

	// A phase write legally moves the next tick, so spacing is only checked while phase holds
	a_tick_once_per_pixel: assert property (ce && pix_tick && !ext_sel && $stable(phase)
		##1 (ce && !ext_sel && $stable(phase))[*3] |-> !pix_tick && !$past(pix_tick))
		else $error("pixel tick spacing wrong");

endmodule : pxo_strobe_gen

// ---- hdl/pxo_port.sv ----
`timescale 1ns/1ps
module pxo_port #(
	parameter int ADDR_W    = 10,
	parameter int LAT_PLAIN = 2,
	parameter int LAT_CSC   = 4
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [7:0]        red_in,
	input  wire logic [7:0]        green_in,
	input  wire logic [7:0]        blue_in,
	input  wire logic              hsync_in,
	input  wire logic              vsync_in,
	input  wire logic              field_in,
	input  wire logic              external_pixel_clock_in,
	output logic [7:0]             red_out,
	output logic [7:0]             green_out,
	output logic [7:0]             blue_out,
	output logic                   line_sync_out,
	output logic                   field_parity_out,
	output logic                   output_strobe_clock,
	output logic [7:0]             config_bus_addr,
	output logic [7:0]             protect_link_addr
);

	localparam int STG_W = 27;  // hsync, vsync, field, 24 colour bits

	// Elaboration check: the word index must be 6 to 8 bits wide, the long tap must cover the short one
	if (ADDR_W < 8 || ADDR_W > 10 || LAT_PLAIN < 1 || LAT_CSC < LAT_PLAIN) begin : g_bad_params
		$error("pxo_port: unsupported parameter values");
	end

	typedef struct packed {
		logic                            awready;
		logic                            wready;
		logic                            bvalid;
		logic [1:0]                      bresp;
		logic                            aw_have;
		logic                            w_have;
		logic [ADDR_W-1:0]               awaddr;
		logic [31:0]                     wdata;
		logic [3:0]                      wstrb;
		logic                            arready;
		logic                            rvalid;
		logic [1:0]                      rresp;
		logic [31:0]                     rdata;
		logic                            strb_inv;
		logic                            field_pol;
		logic [1:0]                      strb_sel;
		logic [1:0]                      phase;
		logic                            ext_sel;
		logic                            csc_en;
		logic                            hs_pol;
		logic                            prot_alt;
		logic [7:0]                      hs_width;
		logic [LAT_CSC-1:0][STG_W-1:0]   pipe;
		logic [7:0]                      red;
		logic [7:0]                      green;
		logic [7:0]                      blue;
		logic                            hs_prev;
		logic                            vs_prev;
		logic [7:0]                      hs_cnt;
		logic                            field_bit;
		logic                            line_sync;
		logic                            field_out;
		logic                            strobe;
		logic [7:0]                      cfg_addr;
		logic [7:0]                      prot_addr;
	} pxo_state_t;

	pxo_state_t r;
	pxo_state_t n;
	logic       pix_tick;
	logic       strobe_raw;

	////////////////////////////////////////////////////////////////////////////
	// Word index of a byte address, shared by read and write decode
	function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
		word_index = 8'(a >> 2);
	endfunction : word_index

	// Byte-lane merge of a write into a 16-bit register image
	function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : lane_merge

	////////////////////////////////////////////////////////////////////////////
	// Strobe and pixel timing generator
	pxo_strobe_gen u_gen (
		.aclk                    (aclk),
		.aresetn                 (aresetn),
		.ce                      (ce),
		.ext_sel                 (r.ext_sel),
		.external_pixel_clock_in (external_pixel_clock_in),
		.phase                   (r.phase),
		.strb_sel                (r.strb_sel),
		.pix_tick                (pix_tick),
		.strobe_raw              (strobe_raw)
	);

	// Every top output is a state field
	assign s_axi_awready       = r.awready;
	assign s_axi_wready        = r.wready;
	assign s_axi_bresp         = r.bresp;
	assign s_axi_bvalid        = r.bvalid;
	assign s_axi_arready       = r.arready;
	assign s_axi_rdata         = r.rdata;
	assign s_axi_rresp         = r.rresp;
	assign s_axi_rvalid        = r.rvalid;
	assign red_out             = r.red;
	assign green_out           = r.green;
	assign blue_out            = r.blue;
	assign line_sync_out       = r.line_sync;
	assign field_parity_out    = r.field_out;
	assign output_strobe_clock = r.strobe;
	assign config_bus_addr     = r.cfg_addr;
	assign protect_link_addr   = r.prot_addr;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic: bus slave, pixel pipeline, sync regeneration
	always_comb begin
		logic [15:0] w16;
		logic [15:0] old16;
		int          tap;
		logic        hs;
		logic        vs;
		logic        fld;
		w16   = '0;
		old16 = '0;
		tap   = 0;
		hs    = 1'b0;
		vs    = 1'b0;
		fld   = 1'b0;
		n     = r;

		// Write commit once both address and data are held; response follows both
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (r.aw_have && r.w_have && !r.bvalid) begin
			n.aw_have = 1'b0;
			n.w_have  = 1'b0;
			n.bvalid  = 1'b1;
			n.bresp   = pxo_pkg::RESP_OKAY;
			case (word_index(r.awaddr))
				pxo_pkg::IDX_OUT_CFG: begin
					old16 = {8'h00, 3'h0, r.field_pol, 3'h0, r.strb_inv};
					w16 = lane_merge(old16, r.wdata, r.wstrb);
					n.strb_inv  = w16[pxo_pkg::BIT_STRB_INV];
					n.field_pol = w16[pxo_pkg::BIT_FIELD_POL];
				end
				pxo_pkg::IDX_STRB_SEL: begin
					old16 = {8'h00, r.strb_sel, 6'h00};
					w16 = lane_merge(old16, r.wdata, r.wstrb);
					n.strb_sel = w16[pxo_pkg::BIT_SEL_LO +: 2];
				end
				pxo_pkg::IDX_PHASE: begin
					w16 = lane_merge({14'h0000, r.phase}, r.wdata, r.wstrb);
					n.phase = w16[1:0];
				end
				pxo_pkg::IDX_CTRL: begin
					old16 = {r.hs_width, 4'h0, r.prot_alt, r.hs_pol, r.csc_en, r.ext_sel};
					w16 = lane_merge(old16, r.wdata, r.wstrb);
					n.ext_sel  = w16[pxo_pkg::BIT_EXT_SEL];
					n.csc_en   = w16[pxo_pkg::BIT_CSC_EN];
					n.hs_pol   = w16[pxo_pkg::BIT_HS_POL];
					n.prot_alt = w16[pxo_pkg::BIT_PROT_ALT];
					n.hs_width = w16[pxo_pkg::BIT_HS_WID_LO +: 8];
				end
				default: n.bresp = pxo_pkg::RESP_SLVERR;   // Unmapped and read-only
			endcase
		end
		if (r.awready && s_axi_awvalid) begin
			n.aw_have = 1'b1;
			n.awaddr  = s_axi_awaddr;
		end
		if (r.wready && s_axi_wvalid) begin
			n.w_have = 1'b1;
			n.wdata  = s_axi_wdata;
			n.wstrb  = s_axi_wstrb;
		end
		// Ready drops while a channel is held, so one write at a time
		n.awready = !n.aw_have && !n.bvalid;
		n.wready  = !n.w_have && !n.bvalid;

		// Read: one cycle from address to data
		if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (r.arready && s_axi_arvalid) begin
			n.rvalid = 1'b1;
			n.rresp  = pxo_pkg::RESP_OKAY;
			n.rdata  = '0;
			case (word_index(s_axi_araddr))
				pxo_pkg::IDX_OUT_CFG: begin
					n.rdata[pxo_pkg::BIT_STRB_INV]  = r.strb_inv;
					n.rdata[pxo_pkg::BIT_FIELD_POL] = r.field_pol;
				end
				pxo_pkg::IDX_STRB_SEL: n.rdata[pxo_pkg::BIT_SEL_LO +: 2] = r.strb_sel;
				pxo_pkg::IDX_PHASE:    n.rdata[1:0] = r.phase;
				pxo_pkg::IDX_CTRL: begin
					n.rdata[pxo_pkg::BIT_EXT_SEL]       = r.ext_sel;
					n.rdata[pxo_pkg::BIT_CSC_EN]        = r.csc_en;
					n.rdata[pxo_pkg::BIT_HS_POL]        = r.hs_pol;
					n.rdata[pxo_pkg::BIT_PROT_ALT]      = r.prot_alt;
					n.rdata[pxo_pkg::BIT_HS_WID_LO +: 8] = r.hs_width;
				end
				pxo_pkg::IDX_STATUS: begin
					n.rdata[pxo_pkg::BIT_ST_FIELD]        = r.field_out;
					n.rdata[pxo_pkg::BIT_ST_LSYNC]        = r.line_sync;
					n.rdata[pxo_pkg::BIT_ST_CFGA_LO +: 8] = r.cfg_addr;
					n.rdata[pxo_pkg::BIT_ST_PRTA_LO +: 8] = r.prot_addr;
				end
				default: n.rresp = pxo_pkg::RESP_SLVERR;
			endcase
		end
		n.arready = !n.rvalid;

		// Pixel pipeline advances on each pixel tick; tap sets the latency
		if (pix_tick) begin
			n.pipe[0] = {hsync_in, vsync_in, field_in, red_in, green_in, blue_in};
			for (int i = 1; i < LAT_CSC; i++) begin
				n.pipe[i] = r.pipe[i-1];
			end
			tap = r.csc_en ? LAT_CSC - 1 : LAT_PLAIN - 1;
			{hs, vs, fld, n.red, n.green, n.blue} = r.pipe[tap];
			n.hs_prev = hs;
			n.vs_prev = vs;
			// Parity is caught only on the vertical sync edge, so it holds through the field
			if (vs && !r.vs_prev) begin
				n.field_bit = fld;
			end
			// Rebuilt line sync starts at the horizontal edge of the same output pixel
			if (hs && !r.hs_prev) begin
				n.hs_cnt = (r.hs_width == 8'h00) ? 8'h01 : r.hs_width;
			end else if (r.hs_cnt != 8'h00) begin
				n.hs_cnt = r.hs_cnt - 8'h01;
			end
		end
		n.line_sync = (n.hs_cnt != 8'h00) ~^ r.hs_pol;
		n.field_out = n.field_bit ^ r.field_pol;
		// Strobe carries the same one-cycle register delay as data and line sync
		n.strobe    = strobe_raw ^ r.strb_inv;
		n.cfg_addr  = pxo_pkg::CFG_BUS_ADDR;
		n.prot_addr = r.prot_alt ? pxo_pkg::PROT_ADDR_B : pxo_pkg::PROT_ADDR_A;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; clock enable freezes everything including the bus
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r          <= '0;
			r.hs_width <= pxo_pkg::HS_WIDTH_RST;
			r.phase    <= pxo_pkg::PHASE_RST;
			r.strb_sel <= pxo_pkg::strb_pixel;
			r.line_sync <= 1'b1;
		end else if (ce) begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Helper for the field hold check
	logic vs_prev_rise;
	assign vs_prev_rise = r.pipe[r.csc_en ? LAT_CSC - 1 : LAT_PLAIN - 1][25] && !r.vs_prev;

	sequence s_hs_edge;
		ce && pix_tick && r.pipe[r.csc_en ? LAT_CSC - 1 : LAT_PLAIN - 1][26] && !r.hs_prev;
	endsequence

	sequence s_frozen_step;
		ce ##1 ce;
	endsequence

	// Output lags the polarity bit by one register, so the polarity is compared one cycle back
	a_field_hold_stable: assert property (s_frozen_step ##0 !($past(pix_tick) && $past(vs_prev_rise))
		&& $past(r.field_pol) == $past(r.field_pol, 2) |-> $stable(field_parity_out))
		else $error("field parity moved outside a field boundary");

	a_field_pol_apply: assert property (ce ##1 ce |-> field_parity_out == ($past(n.field_bit) ^ $past(r.field_pol)))
		else $error("field parity polarity wrong");

	a_line_sync_start: assert property (s_hs_edge ##1 1'b1 |-> line_sync_out == r.hs_pol)
		else $error("line sync did not assert on horizontal edge");

	a_rgb_latency_tap: assert property (ce && pix_tick |=> red_out == $past(r.pipe[r.csc_en ? LAT_CSC - 1
		: LAT_PLAIN - 1][23:16]) && blue_out == $past(r.pipe[r.csc_en ? LAT_CSC - 1 : LAT_PLAIN - 1][7:0]))
		else $error("colour output latency wrong");

	a_strobe_invert_bit: assert property (s_frozen_step |-> output_strobe_clock == ($past(strobe_raw) ^ $past(r.strb_inv)))
		else $error("strobe polarity wrong");

	// Addresses read zero through the reset cycle, so only cycles after a clocked update count
	a_config_addr_fixed: assert property (ce && aresetn ##1 1'b1 |-> config_bus_addr == pxo_pkg::CFG_BUS_ADDR)
		else $error("configuration address wrong");

	a_protect_addr_pick: assert property (ce && aresetn ##1 1'b1 |-> protect_link_addr
		== ($past(r.prot_alt) ? pxo_pkg::PROT_ADDR_B : pxo_pkg::PROT_ADDR_A))
		else $error("protection link address wrong");

	a_bvalid_held_wait: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before taken");

	a_rvalid_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");

endmodule : pxo_port

// ---- verif/pxo_sink.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Downstream capture stage: latches colour and line sync on each strobe rise
module pxo_sink (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        strobe,
	input  wire logic [23:0] pix,
	input  wire logic        lsync,
	output logic      [23:0] cap_pix,
	output logic             cap_ls
);
	logic prev_r;

	// Strobe is registered on aclk, so its rise is found by sampling it there
	always @(posedge aclk) begin
		prev_r <= strobe;
		if (!aresetn) begin
			cap_pix <= 24'h0;
			cap_ls  <= 1'b0;
		end else if (strobe && !prev_r) begin
			cap_pix <= pix;
			cap_ls  <= lsync;
		end
	end
endmodule : pxo_sink

// ---- verif/tb_pixel_output_port_clocking.sv ----
`timescale 1ns/1ps
module tb_pixel_output_port_clocking;
	localparam int LP = 2;
	localparam int LC = 4;
	logic        aclk = 0, aresetn = 0, ce = 1;
	logic [9:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  red_in = 0, green_in = 0, blue_in = 0, red_out, green_out, blue_out;
	logic        hsync_in = 0, vsync_in = 0, field_in = 0, external_pixel_clock_in = 0;
	logic        line_sync_out, field_parity_out, output_strobe_clock;
	logic [7:0]  config_bus_addr, protect_link_addr;
	logic [23:0] cap_pix;
	logic        hold_px = 1;
	logic        cap_ls, xph = 0;
	logic [24:0] snap;
	int          seed = 68, miscompares = 0, checked = 0;

	pxo_port #(.LAT_PLAIN(LP), .LAT_CSC(LC)) pxo_port_i (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .red_in, .green_in, .blue_in, .hsync_in, .vsync_in, .field_in, .external_pixel_clock_in,
		.red_out, .green_out, .blue_out, .line_sync_out, .field_parity_out, .output_strobe_clock,
		.config_bus_addr, .protect_link_addr);
	pxo_sink pxo_sink_i (.aclk(aclk), .aresetn(aresetn), .strobe(output_strobe_clock),
		.pix({red_out, green_out, blue_out}), .lsync(line_sync_out), .cap_pix(cap_pix), .cap_ls(cap_ls));

	// Bus clock; external pixel clock of four bus cycles, stepped on the rising edge
	always #10 aclk = ~aclk;
	always @(posedge aclk) {external_pixel_clock_in, xph} <= {external_pixel_clock_in, xph} + 2'h1;
	// Random pixels every cycle unless a test needs a quiet input
	always @(posedge aclk) if (!hold_px) {red_in, green_in, blue_in} <= 24'($random(seed));

	////////////////////////////////////////////////////////////////////////////
	// Expected strobe rises in 32 cycles of four-cycle pixels
	function automatic int exp_rises(input logic [1:0] sel);
		case (sel)
			2'h0: return 4;
			2'h2: return 16;
			default: return 8;
		endcase
	endfunction : exp_rises

	function automatic logic [9:0] ad(input logic [7:0] idx);
		return {idx, 2'h0};
	endfunction : ad

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk

	// Write with both channels offered together, each released when taken
	task automatic wchk(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= ad(idx);
		s_axi_awvalid <= 1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		chk("write handshake", 1, s_axi_bvalid);
		chk("write resp", er, s_axi_bresp);
		s_axi_bready <= 0;
		@(posedge aclk);
	endtask : wchk

	task automatic rchk(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= ad(idx);
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		chk("read handshake", 1, s_axi_rvalid);
		chk("read resp", er, s_axi_rresp);
		chk("read data", e, s_axi_rdata);
		s_axi_rready <= 0;
		@(posedge aclk);
	endtask : rchk

	task automatic rises(input logic [1:0] sel);
		int  c;
		logic p;
		c = 0;
		p = output_strobe_clock;
		repeat (32) begin
			@(posedge aclk);
			if (output_strobe_clock && !p) c++;
			p = output_strobe_clock;
		end
		chk("strobe rises", exp_rises(sel), c);
	endtask : rises

	// Strobe level when colour changes; with no inversion the sink must have caught that colour
	task automatic align(input logic inv);
		logic [23:0] p;
		logic pend;
		p = {red_out, green_out, blue_out};
		pend = 0;
		repeat (40) begin
			@(posedge aclk);
			if (pend) chk("sink capture", p, cap_pix);
			pend = 0;
			if ({red_out, green_out, blue_out} !== p) begin
				chk("strobe at change", !inv, output_strobe_clock);
				pend = !inv;
			end
			p = {red_out, green_out, blue_out};
		end
	endtask : align

	task automatic lat(input int l);
		int c;
		hold_px <= 1;
		{red_in, green_in, blue_in} <= 24'h0;
		repeat (40) @(posedge aclk);
		{red_in, green_in, blue_in} <= 24'h814218;
		c = 0;
		while ({red_out, green_out, blue_out} !== 24'h814218 && c < 60) begin
			@(posedge aclk);
			c++;
		end
		chk("colour out", 24'h814218, {red_out, green_out, blue_out});
		chk("latency", 1, c >= 4 * l + 1 && c <= 4 * l + 7);
		hold_px <= 0;
	endtask : lat

	// Lead-in lets the sink settle on the new idle level before the pulse is counted
	task automatic ls(input int e, input logic act);
		int c;
		int k;
		c = 0;
		k = 0;
		repeat (8) @(posedge aclk);
		hsync_in <= 1;
		for (int i = 0; i < 88; i++) begin
			@(posedge aclk);
			if (i == 7) hsync_in <= 0;
			if (line_sync_out === act) c++;
			if (cap_ls === act) k++;
		end
		chk("line sync cycles", e, c);
		chk("captured line sync", e, k);
	endtask : ls

	task automatic vs(input logic f);
		field_in <= f;
		vsync_in <= 1;
		repeat (8) @(posedge aclk);
		vsync_in <= 0;
		repeat (24) @(posedge aclk);
	endtask : vs

	task report_and_stop;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////////
	// Hang guard, far beyond the roughly one thousand cycles the sequence takes
	initial begin
		#400000;
		miscompares++;
		report_and_stop;
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge aclk);
		chk("cfg addr in reset", 8'h00, config_bus_addr);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		hold_px <= 0;
		chk("cfg addr", pxo_pkg::CFG_BUS_ADDR, config_bus_addr);
		chk("protect addr", pxo_pkg::PROT_ADDR_A, protect_link_addr);
		rchk(pxo_pkg::IDX_OUT_CFG, 32'h0, pxo_pkg::RESP_OKAY);
		rchk(pxo_pkg::IDX_STRB_SEL, 32'h40, pxo_pkg::RESP_OKAY);
		rchk(pxo_pkg::IDX_CTRL, 32'h800, pxo_pkg::RESP_OKAY);
		wchk(pxo_pkg::IDX_STATUS, 32'hffffffff, pxo_pkg::RESP_SLVERR);
		wchk(8'hff, 32'h1, pxo_pkg::RESP_SLVERR);
		rchk(8'hff, 32'h0, pxo_pkg::RESP_SLVERR);
		// Every strobe option; unused bits of the select word read zero
		for (int s = 0; s < 4; s++) begin
			wchk(pxo_pkg::IDX_STRB_SEL, 32'(s << 6) | 32'hff00ff3f, pxo_pkg::RESP_OKAY);
			rchk(pxo_pkg::IDX_STRB_SEL, 32'(s << 6), pxo_pkg::RESP_OKAY);
			rises(2'(s));
		end
		wchk(pxo_pkg::IDX_STRB_SEL, 32'h40, pxo_pkg::RESP_OKAY);
		align(0);
		// Clock enable low freezes strobe and colour outputs
		ce <= 0;
		@(posedge aclk);
		snap = {output_strobe_clock, red_out, green_out, blue_out};
		repeat (12) begin
			@(posedge aclk);
			chk("frozen outputs", snap, {output_strobe_clock, red_out, green_out, blue_out});
		end
		ce <= 1;
		wchk(pxo_pkg::IDX_OUT_CFG, 32'h1, pxo_pkg::RESP_OKAY);
		align(1);
		wchk(pxo_pkg::IDX_OUT_CFG, 32'h0, pxo_pkg::RESP_OKAY);
		wchk(pxo_pkg::IDX_PHASE, 32'h2, pxo_pkg::RESP_OKAY);
		align(0);
		lat(LP);
		wchk(pxo_pkg::IDX_CTRL, 32'h802, pxo_pkg::RESP_OKAY);
		lat(LC);
		wchk(pxo_pkg::IDX_CTRL, 32'h800, pxo_pkg::RESP_OKAY);
		ls(32, 0);
		wchk(pxo_pkg::IDX_CTRL, 32'h304, pxo_pkg::RESP_OKAY);
		ls(12, 1);
		wchk(pxo_pkg::IDX_CTRL, 32'h004, pxo_pkg::RESP_OKAY);
		ls(4, 1);
		// Upper byte lane alone: width changes, low control bits keep their value
		s_axi_wstrb <= 4'h2;
		wchk(pxo_pkg::IDX_CTRL, 32'h000008ff, pxo_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rchk(pxo_pkg::IDX_CTRL, 32'h00000804, pxo_pkg::RESP_OKAY);
		wchk(pxo_pkg::IDX_CTRL, 32'h800, pxo_pkg::RESP_OKAY);
		// Field parity follows vsync boundaries only, polarity applies at once
		vs(1);
		chk("field parity", 1, field_parity_out);
		field_in <= 0;
		repeat (24) @(posedge aclk);
		chk("field held", 1, field_parity_out);
		wchk(pxo_pkg::IDX_OUT_CFG, 32'h10, pxo_pkg::RESP_OKAY);
		chk("field inverted", 0, field_parity_out);
		vs(0);
		chk("field even inv", 1, field_parity_out);
		wchk(pxo_pkg::IDX_CTRL, 32'h808, pxo_pkg::RESP_OKAY);
		chk("protect alt", pxo_pkg::PROT_ADDR_B, protect_link_addr);
		rchk(pxo_pkg::IDX_STATUS, 32'h00769803, pxo_pkg::RESP_OKAY);
		// External clock takes over the pixel timing
		wchk(pxo_pkg::IDX_CTRL, 32'h801, pxo_pkg::RESP_OKAY);
		repeat (16) @(posedge aclk);
		rises(2'h1);
		align(0);
		report_and_stop;
	end
endmodule : tb_pixel_output_port_clocking
